// ==== hdl/gsem_status.sv ====
// Functional notes
// - Talk with idle formatter and empty queue: query error, code 3, parser reset.
// - Pending response plus terminator or multiple END: query error code 1, flush.
// - Queue turning full while a response is pending: query error code 2, flush formatter.
// - Poll status high when poll mask AND status byte is nonzero.
// - Poll mask written by numeric command, read by query.
// - Enable byte: bits 6..4 equal 110, bit 3 sense, bits 2..0 line.
// - Event summary bit 5 set when enabled event flag present.
// - Event flag query returns then clears; event mask writable and readable.
// - Event layout: 7 power-on, 5 command, 4 execution, 2 query, 0 complete.
// - Syntax error sets command error and resets the parser.
// - Execution failure sets execution error and stores its code.
// - Operation complete command sets operation complete flag.
// - Enabled status bit sets bit 6 and requests service.
// - Query returns summary in bit 6; serial poll returns request bit.
// - Service mask written by numeric command, read by query.
// - Message-available bit set when response ready, cleared after terminator.
// - Power-on: all zero except event flags at 128.
// - Bus functions include service request, poll, clear; no controller.
// - Power-on enters local state with front panel enabled.
// - Corrupt settings at power-up raise warning and load reset defaults.
// - Input queue of 256 bytes; filling up while a response is pending triggers deadlock.
`timescale 1ns/1ps
`default_nettype none
`include "gsem_consts.svh"

module gsem_status #(
    parameter int QUEUE_DEPTH = `GSEM_QUEUE_DEPTH
) (
    // Clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 srst_i,
    // Parser and formatter events
    input  wire gsem_pkg::gsem_evt_t  evt_i,
    input  wire logic                 queue_wr_i,
    input  wire logic                 queue_rd_i,
    input  wire logic                 dev_clear_i,
    input  wire logic                 nv_corrupt_i,
    // Remote and local
    input  wire logic                 remote_cmd_i,
    input  wire logic                 local_key_i,
    // Common command access
    input  wire gsem_pkg::gsem_wr_sel_t wr_sel_i,
    input  wire logic [7:0]           wr_data_i,
    input  wire gsem_pkg::gsem_rd_sel_t rd_sel_i,
    output logic [7:0]                rd_data_o,
    // Bus poll messages
    input  wire logic                 ppc_i,
    input  wire logic                 ppe_i,
    input  wire logic                 ppu_i,
    input  wire logic [7:0]           cmd_byte_i,
    input  wire logic                 spoll_i,
    output logic [7:0]                spoll_byte_o,
    output logic                      srq_o,
    output logic                      ist_o,
    output logic                      pp_active_o,
    output logic                      pp_sense_o,
    output logic [2:0]                pp_line_o,
    // Parser and formatter control
    output logic                      parser_reset_o,
    output logic                      formatter_flush_o,
    output logic                      queue_full_o,
    output logic                      remote_o,
    output logic                      nv_warning_o,
    output logic                      load_defaults_o
);

    localparam int CW = $clog2(QUEUE_DEPTH + 1);

    if (QUEUE_DEPTH < 2) begin : g_depth_check
        $error("QUEUE_DEPTH too small");
    end

    logic [7:0]       evt_ff;
    logic [7:0]       ese_ff;
    logic [7:0]       sre_ff;
    logic [7:0]       pre_ff;
    logic [7:0]       exe_err_ff;
    logic [7:0]       qry_err_ff;
    logic             mav_ff;
    logic             pending_ff;
    logic [CW-1:0]    qcnt_ff;
    logic [CW-1:0]    nxt_qcnt;
    logic             full_seen_ff;
    logic             por_ff;
    gsem_pkg::gsem_pp_state_t pp_state_ff;
    logic [2:0]       pp_line_ff;
    logic             pp_sense_ff;
    logic [7:0]       spoll_ff;
    logic [7:0]       rd_ff;
    logic             remote_ff;
    logic             warn_ff;

    logic             unterminated;
    logic             interrupted;
    logic             deadlock;
    logic             qry_err;
    logic             esb;
    logic             mss;
    logic [7:0]       stb_base;
    logic [7:0]       stb_query;
    logic             esr_read;

    // Queue occupancy
    always_comb begin
        nxt_qcnt = qcnt_ff;
        if (queue_wr_i && !queue_rd_i && qcnt_ff != CW'(QUEUE_DEPTH)) begin
            nxt_qcnt = qcnt_ff + CW'(1);
        end else if (queue_rd_i && !queue_wr_i && qcnt_ff != '0) begin
            nxt_qcnt = qcnt_ff - CW'(1);
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i || dev_clear_i) begin
            qcnt_ff <= '0;
        end else begin
            qcnt_ff <= nxt_qcnt;
        end
    end

    assign queue_full_o = (qcnt_ff == CW'(QUEUE_DEPTH));

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            full_seen_ff <= 1'b0;
        end else begin
            full_seen_ff <= queue_full_o;
        end
    end

    // Error detection
    assign unterminated = evt_i.talk_addressed && !pending_ff && qcnt_ff == '0;
    assign interrupted  = pending_ff && (evt_i.terminator_read || evt_i.multi_end);
    assign deadlock     = pending_ff && queue_full_o && !full_seen_ff;
    assign qry_err      = unterminated || interrupted || deadlock;

    assign parser_reset_o    = unterminated || evt_i.syntax_err;
    assign formatter_flush_o = interrupted || deadlock;

    // Pending response and message available
    always_ff @(posedge clock_i) begin
        if (srst_i || dev_clear_i) begin
            pending_ff <= 1'b0;
            mav_ff     <= 1'b0;
        end else if (evt_i.response_ready) begin
            pending_ff <= 1'b1;
            mav_ff     <= 1'b1;
        end else if (formatter_flush_o || evt_i.terminator_sent) begin
            pending_ff <= 1'b0;
            mav_ff     <= 1'b0;
        end
    end

    // Query error code
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            qry_err_ff <= `GSEM_ZERO_BYTE;
        end else if (unterminated) begin
            qry_err_ff <= `GSEM_QERR_UNTERMINATED;
        end else if (interrupted) begin
            qry_err_ff <= `GSEM_QERR_INTERRUPTED;
        end else if (deadlock) begin
            qry_err_ff <= `GSEM_QERR_DEADLOCK;
        end
    end

    // Execution error code
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            exe_err_ff <= `GSEM_ZERO_BYTE;
        end else if (evt_i.exec_fail) begin
            exe_err_ff <= evt_i.exec_code;
        end
    end

    // Standard event flags: sets win over the clear by read
    assign esr_read = (rd_sel_i == gsem_pkg::GSEM_RD_ESR);

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            evt_ff <= `GSEM_EVT_RESET;
        end else begin
            if (esr_read) begin
                evt_ff <= `GSEM_ZERO_BYTE;
            end
            if (evt_i.syntax_err) begin
                evt_ff[`GSEM_EVT_CMD_ERR] <= 1'b1;
            end
            if (evt_i.exec_fail) begin
                evt_ff[`GSEM_EVT_EXE_ERR] <= 1'b1;
            end
            if (qry_err) begin
                evt_ff[`GSEM_EVT_QRY_ERR] <= 1'b1;
            end
            if (evt_i.opc_exec) begin
                evt_ff[`GSEM_EVT_OPC] <= 1'b1;
            end
        end
    end

    // Enable masks
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ese_ff <= `GSEM_ZERO_BYTE;
            sre_ff <= `GSEM_ZERO_BYTE;
            pre_ff <= `GSEM_ZERO_BYTE;
        end else begin
            case (wr_sel_i)
                gsem_pkg::GSEM_WR_ESE: ese_ff <= wr_data_i & `GSEM_EVT_USED_MASK;
                gsem_pkg::GSEM_WR_SRE: sre_ff <= wr_data_i & `GSEM_SRE_USED_MASK;
                gsem_pkg::GSEM_WR_PRE: pre_ff <= wr_data_i;
                default: ;
            endcase
        end
    end

    // Status byte summary
    assign esb = |(evt_ff & ese_ff & `GSEM_EVT_USED_MASK);
    always_comb begin
        stb_base = `GSEM_ZERO_BYTE;
        stb_base[`GSEM_STB_ESB] = esb;
        stb_base[`GSEM_STB_MAV] = mav_ff;
    end
    assign mss = |(stb_base & sre_ff);
    always_comb begin
        stb_query = stb_base;
        stb_query[`GSEM_STB_RQS] = mss;
    end

    // Service request held until serial polled or the summary drops
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            srq_o <= 1'b0;
        end else if (mss && !srq_o && !spoll_i) begin
            srq_o <= 1'b1;
        end else if (spoll_i || !mss) begin
            srq_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            spoll_ff <= `GSEM_ZERO_BYTE;
        end else if (spoll_i) begin
            spoll_ff <= {stb_base[7], srq_o, stb_base[5:0]};
        end
    end
    assign spoll_byte_o = spoll_ff;

    // Local poll status
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ist_o <= 1'b0;
        end else begin
            ist_o <= |(pre_ff & stb_query);
        end
    end

    // Parallel poll configuration
    always_ff @(posedge clock_i) begin
        if (srst_i || ppu_i) begin
            pp_state_ff <= gsem_pkg::GSEM_PP_IDLE;
            pp_line_ff  <= 3'h0;
            pp_sense_ff <= 1'b0;
        end else begin
            case (pp_state_ff)
                gsem_pkg::GSEM_PP_IDLE: if (ppc_i) pp_state_ff <= gsem_pkg::GSEM_PP_CFG;
                gsem_pkg::GSEM_PP_CFG, gsem_pkg::GSEM_PP_ARM: begin
                    if (ppe_i && cmd_byte_i[6:4] == `GSEM_PPE_TAG) begin
                        pp_state_ff <= gsem_pkg::GSEM_PP_ARM;
                        pp_sense_ff <= cmd_byte_i[`GSEM_PPE_SENSE];
                        pp_line_ff  <= cmd_byte_i[2:0];
                    end
                end
                default: pp_state_ff <= gsem_pkg::GSEM_PP_IDLE;
            endcase
        end
    end
    assign pp_active_o = (pp_state_ff == gsem_pkg::GSEM_PP_ARM);
    assign pp_sense_o  = pp_sense_ff;
    assign pp_line_o   = pp_line_ff;

    // Readback
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rd_ff <= `GSEM_ZERO_BYTE;
        end else begin
            case (rd_sel_i)
                gsem_pkg::GSEM_RD_ESR: rd_ff <= evt_ff & `GSEM_EVT_USED_MASK;
                gsem_pkg::GSEM_RD_ESE: rd_ff <= ese_ff;
                gsem_pkg::GSEM_RD_STB: rd_ff <= stb_query;
                gsem_pkg::GSEM_RD_SRE: rd_ff <= sre_ff;
                gsem_pkg::GSEM_RD_PRE: rd_ff <= pre_ff;
                gsem_pkg::GSEM_RD_EXE: rd_ff <= exe_err_ff;
                gsem_pkg::GSEM_RD_QRY: rd_ff <= qry_err_ff;
                default: rd_ff <= rd_ff;
            endcase
        end
    end
    assign rd_data_o = rd_ff;

    // Remote and local
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            remote_ff <= 1'b0;
        end else if (remote_cmd_i) begin
            remote_ff <= 1'b1;
        end else if (local_key_i) begin
            remote_ff <= 1'b0;
        end
    end
    assign remote_o = remote_ff;

    // Nonvolatile check, sampled once after reset
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            por_ff  <= 1'b1;
            warn_ff <= 1'b0;
            load_defaults_o <= 1'b0;
        end else begin
            por_ff <= 1'b0;
            load_defaults_o <= por_ff && nv_corrupt_i;
            if (por_ff && nv_corrupt_i) begin
                warn_ff <= 1'b1;
            end
        end
    end
    assign nv_warning_o = warn_ff;

endmodule : gsem_status

`default_nettype wire

// ==== pkg/gsem_consts.svh ====
`ifndef GSEM_CONSTS_SVH
`define GSEM_CONSTS_SVH

// Standard event flag positions
`define GSEM_EVT_PON       7
`define GSEM_EVT_CMD_ERR   5
`define GSEM_EVT_EXE_ERR   4
`define GSEM_EVT_QRY_ERR   2
`define GSEM_EVT_OPC       0
`define GSEM_EVT_USED_MASK 8'hb5

// Status byte positions
`define GSEM_STB_RQS       6
`define GSEM_STB_ESB       5
`define GSEM_STB_MAV       4
`define GSEM_STB_USED_MASK 8'h70
`define GSEM_SRE_USED_MASK 8'h30

// Reset values
`define GSEM_EVT_RESET     8'h80
`define GSEM_ZERO_BYTE     8'h00

// Query error codes
`define GSEM_QERR_INTERRUPTED  8'h01
`define GSEM_QERR_DEADLOCK     8'h02
`define GSEM_QERR_UNTERMINATED 8'h03

// Parallel poll enable byte decode
`define GSEM_PPE_TAG       3'h6
`define GSEM_PPE_SENSE     3

// Input queue depth
`define GSEM_QUEUE_DEPTH   256

`endif

// ==== pkg/gsem_pkg.sv ====
`default_nettype none
package gsem_pkg;

    typedef enum logic [2:0] {
        GSEM_WR_NONE = 3'h0,
        GSEM_WR_ESE  = 3'h1,
        GSEM_WR_SRE  = 3'h2,
        GSEM_WR_PRE  = 3'h3
    } gsem_wr_sel_t;

    typedef enum logic [2:0] {
        GSEM_RD_NONE = 3'h0,
        GSEM_RD_ESR  = 3'h1,
        GSEM_RD_ESE  = 3'h2,
        GSEM_RD_STB  = 3'h3,
        GSEM_RD_SRE  = 3'h4,
        GSEM_RD_PRE  = 3'h5,
        GSEM_RD_EXE  = 3'h6,
        GSEM_RD_QRY  = 3'h7
    } gsem_rd_sel_t;

    typedef struct packed {
        logic opc_exec;
        logic syntax_err;
        logic exec_fail;
        logic [7:0] exec_code;
        logic terminator_read;
        logic multi_end;
        logic talk_addressed;
        logic response_ready;
        logic terminator_sent;
    } gsem_evt_t;

    typedef enum logic [1:0] {
        GSEM_PP_IDLE = 2'b00,
        GSEM_PP_CFG  = 2'b01,
        GSEM_PP_ARM  = 2'b11
    } gsem_pp_state_t;

endpackage : gsem_pkg
`default_nettype wire

// ==== sim/gsem_status_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module gsem_status_sva (
    // Clock and reset
    input wire logic                   clock_i,
    input wire logic                   srst_i,
    // Requests
    input wire gsem_pkg::gsem_evt_t    evt_i,
    input wire gsem_pkg::gsem_wr_sel_t wr_sel_i,
    input wire logic [7:0]             wr_data_i,
    input wire gsem_pkg::gsem_rd_sel_t rd_sel_i,
    input wire logic                   ppc_i,
    input wire logic                   ppe_i,
    input wire logic [7:0]             cmd_byte_i,
    input wire logic                   spoll_i,
    // Answers
    input wire logic [7:0]             rd_data_o,
    input wire logic [7:0]             spoll_byte_o,
    input wire logic                   srq_o,
    input wire logic                   pp_active_o,
    input wire logic                   pp_sense_o,
    input wire logic [2:0]             pp_line_o,
    input wire logic                   parser_reset_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    chk_syntax_parser: assert property (evt_i.syntax_err |-> parser_reset_o)
        else $error("syntax error without parser reset");
    chk_ese_readback: assert property (
        (wr_sel_i == 3'h1) ##1 (wr_sel_i == 3'h0) ##1 (rd_sel_i == 3'h2 && wr_sel_i == 3'h0)
        |=> rd_data_o == ($past(wr_data_i, 3) & 8'hb5)) else $error("event mask readback");
    chk_sre_readback: assert property (
        (wr_sel_i == 3'h2) ##1 (wr_sel_i == 3'h0) ##1 (rd_sel_i == 3'h4 && wr_sel_i == 3'h0)
        |=> rd_data_o == ($past(wr_data_i, 3) & 8'h30)) else $error("service mask readback");
    chk_pre_readback: assert property (
        (wr_sel_i == 3'h3) ##1 (wr_sel_i == 3'h0) ##1 (rd_sel_i == 3'h5 && wr_sel_i == 3'h0)
        |=> rd_data_o == $past(wr_data_i, 3)) else $error("poll mask readback");
    chk_esr_cleared: assert property (
        (rd_sel_i == 3'h1 && evt_i == '0) ##1 (rd_sel_i == 3'h0 && evt_i == '0)
        ##1 (rd_sel_i == 3'h1 && evt_i == '0)
        |=> rd_data_o == 8'h00) else $error("event flags not cleared by read");
    chk_poll_clears: assert property (spoll_i |=> !srq_o)
        else $error("service request kept after serial poll");
    chk_poll_rqs: assert property (spoll_i |=> spoll_byte_o[6] == $past(srq_o))
        else $error("serial poll bit 6 differs from request");
    chk_ppe_decode: assert property (
        $past(ppc_i) && ppe_i && cmd_byte_i[6:4] == 3'h6
        |=> pp_active_o && pp_sense_o == $past(cmd_byte_i[3])
        && pp_line_o == $past(cmd_byte_i[2:0])) else $error("poll enable byte decode");
    chk_ppe_reject: assert property (
        ppe_i && cmd_byte_i[6:4] != 3'h6 && !pp_active_o |=> !pp_active_o)
        else $error("bad poll enable byte accepted");
endmodule : gsem_status_sva

bind gsem_status gsem_status_sva u_sva (.clock_i, .srst_i, .evt_i, .wr_sel_i, .wr_data_i,
    .rd_sel_i, .ppc_i, .ppe_i, .cmd_byte_i, .spoll_i, .rd_data_o, .spoll_byte_o, .srq_o,
    .pp_active_o, .pp_sense_o, .pp_line_o, .parser_reset_o);
`default_nettype wire

// ==== sim/gsem_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module gsem_ctrl_model (
    // Clock
    input  wire logic  clock_i,
    // Poll messages to the device
    output logic       ppc_o,
    output logic       ppe_o,
    output logic       ppu_o,
    output logic       spoll_o,
    output logic [7:0] cmd_o
);
    initial begin
        ppc_o = 1'b0;
        ppe_o = 1'b0;
        ppu_o = 1'b0;
        spoll_o = 1'b0;
        cmd_o = 8'h00;
    end
    // Configure first, then the enable byte; byte line inverted once released
    task automatic arm(input logic [7:0] b);
        @(posedge clock_i);
        #1 ppc_o = 1'b1;
        @(posedge clock_i);
        #1 ppc_o = 1'b0;
        ppe_o = 1'b1;
        cmd_o = b;
        @(posedge clock_i);
        #1 ppe_o = 1'b0;
        cmd_o = ~b;
    endtask : arm
    // Leave the configured state
    task automatic unconfig();
        @(posedge clock_i);
        #1 ppu_o = 1'b1;
        @(posedge clock_i);
        #1 ppu_o = 1'b0;
    endtask : unconfig
    // Enable byte without a configure command ahead of it
    task automatic stray(input logic [7:0] b);
        @(posedge clock_i);
        #1 ppe_o = 1'b1;
        cmd_o = b;
        @(posedge clock_i);
        #1 ppe_o = 1'b0;
        cmd_o = ~b;
    endtask : stray
    task automatic poll();
        @(posedge clock_i);
        #1 spoll_o = 1'b1;
        @(posedge clock_i);
        #1 spoll_o = 1'b0;
    endtask : poll
endmodule : gsem_ctrl_model
`default_nettype wire

// ==== sim/gsem_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpib_status_and_error_model_bench;
    localparam int QD = 4;
    logic                   clock_i, srst_i, queue_wr_i, queue_rd_i, ppc_i, ppe_i, spoll_i;
    logic                   nv_corrupt_i, remote_cmd_i, local_key_i, ppu_i;
    logic                   remote_o, nv_warning_o, load_defaults_o, formatter_flush_o;
    logic                   srq_o, ist_o, pp_active_o, pp_sense_o, queue_full_o;
    logic [2:0]             pp_line_o;
    logic [7:0]             wr_data_i, cmd_byte_i, rd_data_o, spoll_byte_o;
    gsem_pkg::gsem_evt_t    evt_i, e;
    gsem_pkg::gsem_wr_sel_t wr_sel_i;
    gsem_pkg::gsem_rd_sel_t rd_sel_i;
    int                     n_fail, n_compared, standard_event_flags, ese, sre, pre, exe, qry, mav, r, n_flush;

    gsem_status #(.QUEUE_DEPTH(QD)) uut (.clock_i, .srst_i, .evt_i, .queue_wr_i, .queue_rd_i,
        .dev_clear_i(1'b0), .nv_corrupt_i, .remote_cmd_i, .local_key_i,
        .wr_sel_i, .wr_data_i, .rd_sel_i, .rd_data_o, .ppc_i, .ppe_i, .ppu_i,
        .cmd_byte_i, .spoll_i, .spoll_byte_o, .srq_o, .ist_o, .pp_active_o, .pp_sense_o,
        .pp_line_o, .parser_reset_o(), .formatter_flush_o, .queue_full_o, .remote_o,
        .nv_warning_o, .load_defaults_o);
    gsem_ctrl_model ctl (.clock_i, .ppc_o(ppc_i), .ppe_o(ppe_i), .ppu_o(ppu_i),
        .spoll_o(spoll_i), .cmd_o(cmd_byte_i));

    // Count formatter flush pulses
    always @(posedge clock_i) begin
        if (formatter_flush_o === 1'b1) n_flush++;
    end

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic step();
        @(posedge clock_i);
        #1;
    endtask : step
    task automatic chk(input logic [7:0] got, input int exp);
        n_compared++;
        if (got !== exp[7:0]) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp[7:0]);
        end
    endtask : chk
    function automatic int stb();
        int s;
        s = (mav << 4) | (int'((standard_event_flags & ese) != 0) << 5);
        return s | (int'((s & sre) != 0) << 6);
    endfunction : stb
    task automatic ev(input gsem_pkg::gsem_evt_t v);
        evt_i = v;
        step();
        evt_i = '0;
        step();
    endtask : ev
    task automatic wr(input gsem_pkg::gsem_wr_sel_t s, input int d);
        wr_sel_i = s;
        wr_data_i = d[7:0];
        if (s == gsem_pkg::GSEM_WR_ESE) ese = d & 'hb5;
        if (s == gsem_pkg::GSEM_WR_SRE) sre = d & 'h30;
        if (s == gsem_pkg::GSEM_WR_PRE) pre = d & 'hff;
        step();
        wr_sel_i = gsem_pkg::GSEM_WR_NONE;
        step();
    endtask : wr
    task automatic rd(input gsem_pkg::gsem_rd_sel_t s);
        int m[8];
        m = '{0, standard_event_flags, ese, stb(), sre, pre, exe, qry};
        rd_sel_i = s;
        step();
        rd_sel_i = gsem_pkg::GSEM_RD_NONE;
        chk(rd_data_o, m[s]);
        if (s == gsem_pkg::GSEM_RD_ESR) standard_event_flags = 0;
        step();
    endtask : rd
    task automatic test_done();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    initial begin
        #100000;
        n_fail++;
        $display("watchdog expired");
        test_done();
    end
    initial begin
        {queue_wr_i, queue_rd_i, wr_data_i, nv_corrupt_i, remote_cmd_i, local_key_i} = '0;
        evt_i = '0;
        wr_sel_i = gsem_pkg::GSEM_WR_NONE;
        rd_sel_i = gsem_pkg::GSEM_RD_NONE;
        srst_i = 1'b1;
        standard_event_flags = 128;
        r = $urandom(56);
        repeat (8) @(posedge clock_i);
        #1 srst_i = 1'b0;
        rd(gsem_pkg::GSEM_RD_ESR);
        rd(gsem_pkg::GSEM_RD_ESR);
        for (int k = 2; k < 8; k++) rd(gsem_pkg::gsem_rd_sel_t'(k));
        chk({7'h0, remote_o}, 0);
        remote_cmd_i = 1'b1;
        step();
        remote_cmd_i = 1'b0;
        chk({7'h0, remote_o}, 1);
        local_key_i = 1'b1;
        step();
        local_key_i = 1'b0;
        chk({7'h0, remote_o}, 0);
        chk({6'h0, nv_warning_o, load_defaults_o}, 0);
        $display("power-on values done");
        for (int k = 1; k < 4; k++) begin
            wr(gsem_pkg::gsem_wr_sel_t'(k), $urandom);
            rd(gsem_pkg::gsem_rd_sel_t'(2 * k - k / 3));
        end
        $display("mask access done");
        wr(gsem_pkg::GSEM_WR_ESE, 'h20);
        wr(gsem_pkg::GSEM_WR_SRE, 'h20);
        wr(gsem_pkg::GSEM_WR_PRE, 'h40);
        e = '0;
        e.syntax_err = 1'b1;
        ev(e);
        standard_event_flags |= 'h20;
        chk({7'h0, srq_o}, 1);
        chk({7'h0, ist_o}, 1);
        rd(gsem_pkg::GSEM_RD_STB);
        ctl.arm(8'h29);
        chk({7'h0, pp_active_o}, 0);
        ctl.arm(8'h69);
        chk({3'h0, pp_active_o, pp_sense_o, pp_line_o}, 'h19);
        ctl.poll();
        chk(spoll_byte_o, stb());
        chk({7'h0, srq_o}, 0);
        ctl.unconfig();
        chk({3'h0, pp_active_o, pp_sense_o, pp_line_o}, 0);
        ctl.stray(8'h69);
        chk({7'h0, pp_active_o}, 0);
        rd(gsem_pkg::GSEM_RD_ESR);
        $display("summary and polls done");
        e = '0;
        e.opc_exec = 1'b1;
        ev(e);
        r = $urandom;
        e = '0;
        e.exec_fail = 1'b1;
        e.exec_code = r[7:0];
        ev(e);
        e = '0;
        e.talk_addressed = 1'b1;
        ev(e);
        {standard_event_flags, exe, qry} = {32'h15, r & 'hff, 32'd3};
        rd(gsem_pkg::GSEM_RD_ESR);
        rd(gsem_pkg::GSEM_RD_EXE);
        rd(gsem_pkg::GSEM_RD_QRY);
        $display("error events done");
        e = '0;
        e.response_ready = 1'b1;
        ev(e);
        mav = 1;
        rd(gsem_pkg::GSEM_RD_STB);
        e = '0;
        e.terminator_sent = 1'b1;
        ev(e);
        mav = 0;
        rd(gsem_pkg::GSEM_RD_STB);
        for (int k = 0; k < 2; k++) begin
            e = '0;
            e.response_ready = 1'b1;
            ev(e);
            e = '0;
            e.terminator_read = (k == 0);
            e.multi_end = (k == 1);
            ev(e);
            qry = 1;
            rd(gsem_pkg::GSEM_RD_QRY);
        end
        e = '0;
        e.response_ready = 1'b1;
        ev(e);
        queue_wr_i = 1'b1;
        repeat (QD) step();
        queue_wr_i = 1'b0;
        chk({7'h0, queue_full_o}, 1);
        step();
        {qry, standard_event_flags} = {32'd2, 32'd4};
        rd(gsem_pkg::GSEM_RD_QRY);
        rd(gsem_pkg::GSEM_RD_ESR);
        chk(n_flush[7:0], 3);
        queue_rd_i = 1'b1;
        repeat (QD) step();
        queue_rd_i = 1'b0;
        chk({7'h0, queue_full_o}, 0);
        $display("query errors done");
        nv_corrupt_i = 1'b1;
        srst_i = 1'b1;
        repeat (2) step();
        srst_i = 1'b0;
        {standard_event_flags, ese, sre, pre, exe, qry, mav} = {32'd128, 192'd0};
        step();
        chk({6'h0, nv_warning_o, load_defaults_o}, 3);
        nv_corrupt_i = 1'b0;
        for (int k = 1; k < 8; k++) rd(gsem_pkg::gsem_rd_sel_t'(k));
        chk({6'h0, nv_warning_o, load_defaults_o}, 2);
        $display("second reset done");
        test_done();
    end
endmodule : gpib_status_and_error_model_bench
`default_nettype wire
